/* rtl/bmc_regs.vh */
// Register map, field positions and timing constants of the battery
// monitor control block. Assumes a 50 MHz core clock.
//
// Summary of operation
// - Wake and enable regulator once cells 1-3 and supply pass power-on thresholds.
// - Stay awake until host sleep command or a monitored supply drops out.
// - Wake edge select 0 wakes on wake pin low, 1 on high.
// - Automatic scan drives sensor bias 5 ms in every 640 ms.
// - Wait 1 ms after bias on, then flag over-temp if thermistor low.
// - Selecting external temperature keeps bias on, routes thermistor, detects after 1 ms.
// - Auto scan off stops periodic scan; auto and manual scans coexist.
// - Bias force holds sensor bias on continuously, overriding both scans.
// - Host writes four-bit monitor select; device routes that selection.
// - Internal and external over-temperature are detected and presented by default.
// - Four user flags, each set or cleared by register write.
// - User flags survive sleep; forced reset clears them with all registers.
// - Slave only: never drives the serial clock, follows master clock.
// - Every byte moves most significant bit first.
// - Data changes only with clock low; changes with clock high are start/stop.
// - Watch for start condition; ignore the bus until one is seen.
// - Stop ends the transaction and returns the port to standby.
// - Control bit 7 puts device to sleep, clears on wake, keeps select.
// - Feature bit 2 forces a power-on reset clearing all registers.
// - Feature bits: 7 auto scan off, 5 bias force, 0 wake edge.
// - Feature writes need unlock bit 7 of write-enable; unlock resets 0.
`ifndef BMC_REGS_VH
`define BMC_REGS_VH

// ----------------------------------------------------------------------
// Serial port
// ----------------------------------------------------------------------
// Slave address value is arbitrary
`define BMC_SLV_ADDR 7'h28
`define BMC_ADDR_LAST 8'h0a

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define BMC_A_MONSEL 8'h03
`define BMC_A_CTRL 8'h04
`define BMC_A_FEAT 8'h07
`define BMC_A_WREN 8'h08

// ----------------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------------
`define BMC_B_SLEEP 7
`define BMC_B_ASOFF 7
`define BMC_B_BFORCE 5
`define BMC_B_FPOR 2
`define BMC_B_WKDIS 1
`define BMC_B_WKEDGE 0
`define BMC_B_UNLOCK 7
`define BMC_B_UF3 4
`define BMC_B_UF2 3
`define BMC_B_UF1 6
`define BMC_B_UF0 5
`define BMC_SEL_EXT 4'h8
`define BMC_RST_FEAT 8'h00
`define BMC_RST_WREN 8'h00
`define BMC_RST_MONSEL 4'h0
// Synchronisers idle: supplies not yet good, wake and bus lines high
`define BMC_RST_SYNC 9'h013

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define BMC_CLK_KHZ 50000
`define BMC_SCAN_WIN_US 5000
`define BMC_SCAN_PER_US 640000
`define BMC_SETTLE_US 1000

`endif

/* rtl/bmc_i2c_slave.v */
// Byte-level serial slave: framing, address match, register pointer.
// Expects scl_s and sda_s already synchronised to clk_i.
`timescale 1ns/100ps
`default_nettype none
`include "bmc_regs.vh"

module bmc_i2c_slave (
  input  wire       clk_i,
  input  wire       rst_n_i,
  input  wire       scl_s_i,
  input  wire       sda_s_i,
  input  wire [7:0] rd_data_i,
  output wire       sda_oe_o,
  output reg        wr_o,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o
);

  localparam S_IDLE = 6'h01;
  localparam S_SLV  = 6'h02;
  localparam S_ADR  = 6'h04;
  localparam S_WR   = 6'h08;
  localparam S_RD   = 6'h10;
  localparam S_MACK = 6'h20;

  reg [5:0] st_q;
  reg [3:0] cnt_q;
  reg [7:0] sh_q;
  reg       ack_q;
  reg       rnw_q;
  reg       nack_q;
  reg       oe_q;
  reg       scl_p_q;
  reg       sda_p_q;

  wire scl_rise = scl_s_i & ~scl_p_q;
  wire scl_fall = ~scl_s_i & scl_p_q;
  // Data edges while the clock is high are framing only
  wire start = scl_s_i & scl_p_q & sda_p_q & ~sda_s_i;
  wire stop  = scl_s_i & scl_p_q & ~sda_p_q & sda_s_i;

  function [7:0] next_ptr;
    input [7:0] p;
    begin
      if (p == `BMC_ADDR_LAST) begin
        next_ptr = 8'h00;
      end else begin
        next_ptr = p + 8'h01;
      end
    end
  endfunction

  // Open drain: only ever pulls low, never touches the clock
  assign sda_oe_o = oe_q;

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q <= S_IDLE;
      cnt_q <= 4'h0;
      sh_q <= 8'h00;
      ack_q <= 1'b0;
      rnw_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      wr_o <= 1'b0;
      addr_o <= 8'h00;
      wdata_o <= 8'h00;
    end else begin
      scl_p_q <= scl_s_i;
      sda_p_q <= sda_s_i;
      wr_o <= 1'b0;
      if (start) begin
        st_q <= S_SLV;
        cnt_q <= 4'h0;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (stop) begin
        st_q <= S_IDLE;
        ack_q <= 1'b0;
        oe_q <= 1'b0;
      end else if (scl_rise) begin
        if (st_q == S_MACK) begin
          nack_q <= sda_s_i;
        end else if (!ack_q && cnt_q != 4'h8 && st_q != S_RD &&
                     st_q != S_IDLE) begin
          sh_q <= {sh_q[6:0], sda_s_i};
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q <= 1'b0;
          oe_q <= 1'b0;
          cnt_q <= 4'h0;
          case (st_q)
            S_SLV: begin
              if (rnw_q) begin
                st_q <= S_RD;
                sh_q <= rd_data_i;
                oe_q <= ~rd_data_i[7];
                cnt_q <= 4'h1;
              end else begin
                st_q <= S_ADR;
              end
            end
            S_ADR: st_q <= S_WR;
            S_WR: addr_o <= next_ptr(addr_o);
            default: st_q <= S_IDLE;
          endcase
        end else if (cnt_q == 4'h8) begin
          case (st_q)
            S_SLV: begin
              if (sh_q[7:1] == `BMC_SLV_ADDR) begin
                ack_q <= 1'b1;
                oe_q <= 1'b1;
                rnw_q <= sh_q[0];
              end else begin
                st_q <= S_IDLE;
              end
            end
            S_ADR: begin
              addr_o <= sh_q;
              ack_q <= 1'b1;
              oe_q <= 1'b1;
            end
            S_WR: begin
              wr_o <= 1'b1;
              wdata_o <= sh_q;
              ack_q <= 1'b1;
              oe_q <= 1'b1;
            end
            S_RD: begin
              oe_q <= 1'b0;
              addr_o <= next_ptr(addr_o);
              st_q <= S_MACK;
            end
            default: st_q <= S_IDLE;
          endcase
        end else if (st_q == S_RD) begin
          oe_q <= ~sh_q[3'h7 - cnt_q[2:0]];
          cnt_q <= cnt_q + 4'h1;
        end else if (st_q == S_MACK) begin
          if (nack_q) begin
            st_q <= S_IDLE;
          end else begin
            st_q <= S_RD;
            sh_q <= rd_data_i;
            oe_q <= ~rd_data_i[7];
            cnt_q <= 4'h1;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

/* rtl/bmc_top.v */
// Control logic of the battery monitor front end: power state, wake,
// thermistor scan, monitor select, user flags and the serial port.
// All inputs except the clock and reset come from outside this domain.
`timescale 1ns/100ps
`default_nettype none
`include "bmc_regs.vh"

module bmc_top #(
  parameter [24:0] SCAN_WIN_CYC =
    `BMC_SCAN_WIN_US * (`BMC_CLK_KHZ / 1000),
  parameter [24:0] SCAN_PER_CYC =
    `BMC_SCAN_PER_US * (`BMC_CLK_KHZ / 1000),
  parameter [24:0] SETTLE_CYC =
    `BMC_SETTLE_US * (`BMC_CLK_KHZ / 1000)
) (
  input  wire       core_clk_i,
  input  wire       nrst_i,
  input  wire [2:0] cell_por_ok_i,
  input  wire       vcc_por_ok_i,
  input  wire       wake_pin_i,
  input  wire       thermistor_low_i,
  input  wire       int_over_temp_i,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output wire       sda_oe_o,
  output wire       regulator_output_o,
  output wire       sensor_bias_out_o,
  output wire [3:0] monitor_select_o,
  output wire       thermistor_route_o,
  output wire       ext_over_temp_o,
  output wire       int_over_temp_o,
  output wire [3:0] user_flags_o
);

  // --------------------------------------------------------------------
  // Reset release
  // --------------------------------------------------------------------
  reg [1:0] rst_sync_q;
  wire      rst_n;

  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_q[1];

  // --------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------
  // Bit order: cells[2:0], vcc, wake, thermistor, int temp, scl, sda
  wire [8:0] async_in;
  reg  [8:0] meta_q;
  reg  [8:0] sync_q;

  assign async_in = {cell_por_ok_i, vcc_por_ok_i, wake_pin_i,
                     thermistor_low_i, int_over_temp_i, scl_i, sda_i};

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= `BMC_RST_SYNC;
      sync_q <= `BMC_RST_SYNC;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  wire por_ok     = &sync_q[8:5];
  wire wake_s     = sync_q[4];
  wire therm_lo_s = sync_q[3];
  wire int_ot_s   = sync_q[2];
  wire scl_s      = sync_q[1];
  wire sda_s      = sync_q[0];

  // --------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------
  wire       wr;
  wire [7:0] addr;
  wire [7:0] wdata;
  reg  [7:0] rd_data;

  bmc_i2c_slave u_slave (
    .clk_i     (core_clk_i),
    .rst_n_i   (rst_n),
    .scl_s_i   (scl_s),
    .sda_s_i   (sda_s),
    .rd_data_i (rd_data),
    .sda_oe_o  (sda_oe_o),
    .wr_o      (wr),
    .addr_o    (addr),
    .wdata_o   (wdata)
  );

  // Open-drain data line only ever pulls low
  assign sda_o = 1'b0;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  reg  [3:0] monsel_q;
  reg  [7:0] feat_q;
  reg  [7:0] wren_q;
  reg        awake_q;
  reg        por_ok_p_q;
  reg        wake_p_q;

  wire wr_monsel = wr && addr == `BMC_A_MONSEL;
  wire wr_ctrl   = wr && addr == `BMC_A_CTRL;
  wire wr_feat   = wr && addr == `BMC_A_FEAT &&
                   wren_q[`BMC_B_UNLOCK];
  wire wr_wren   = wr && addr == `BMC_A_WREN;

  // A forced reset acts like losing a supply, minus the sleep
  wire force_por = wr_feat & wdata[`BMC_B_FPOR];
  wire clr_all   = force_por | ~por_ok;

  wire auto_off   = feat_q[`BMC_B_ASOFF];
  wire bias_force = feat_q[`BMC_B_BFORCE];
  wire wake_dis   = feat_q[`BMC_B_WKDIS];
  wire wake_edge  = feat_q[`BMC_B_WKEDGE];

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      monsel_q <= `BMC_RST_MONSEL;
      feat_q <= `BMC_RST_FEAT;
      wren_q <= `BMC_RST_WREN;
    end else if (clr_all) begin
      monsel_q <= `BMC_RST_MONSEL;
      feat_q <= `BMC_RST_FEAT;
      wren_q <= `BMC_RST_WREN;
    end else begin
      if (wr_monsel) begin
        monsel_q <= wdata[3:0];
      end
      if (wr_feat) begin
        // Bit 2 is an action and bits 4:3 are spare; none is stored
        feat_q <= wdata & 8'he3;
      end
      if (wr_wren) begin
        // Flags sit in plain flops that sleep never touches
        wren_q <= wdata & 8'hf8;
      end
    end
  end

  // --------------------------------------------------------------------
  // Power state
  // --------------------------------------------------------------------
  // Wake only on an edge of the chosen sense, so a pin held at its
  // active level after a sleep command does not wake the device at once
  wire wake_fall = wake_p_q & ~wake_s;
  wire wake_rise = ~wake_p_q & wake_s;
  wire wake_evt  = (wake_edge ? wake_rise : wake_fall) &
                   ~wake_dis;

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      awake_q <= 1'b0;
      por_ok_p_q <= 1'b0;
      wake_p_q <= 1'b1;
    end else begin
      por_ok_p_q <= por_ok;
      wake_p_q <= wake_s;
      if (!por_ok) begin
        awake_q <= 1'b0;
      end else if (!por_ok_p_q) begin
        awake_q <= 1'b1;
      end else if (wr_ctrl && wdata[`BMC_B_SLEEP]) begin
        awake_q <= 1'b0;
      end else if (!awake_q && wake_evt) begin
        awake_q <= 1'b1;
      end
    end
  end

  assign regulator_output_o = awake_q;

  // --------------------------------------------------------------------
  // Automatic thermistor scan
  // --------------------------------------------------------------------
  // Runs from the core clock even while the regulator is off
  reg  [24:0] scan_cnt_q;
  wire        auto_on;

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      scan_cnt_q <= 25'h0;
    end else if (clr_all || auto_off) begin
      scan_cnt_q <= 25'h0;
    end else if (scan_cnt_q == SCAN_PER_CYC - 25'h1) begin
      scan_cnt_q <= 25'h0;
    end else begin
      scan_cnt_q <= scan_cnt_q + 25'h1;
    end
  end

  assign auto_on = ~auto_off & (scan_cnt_q < SCAN_WIN_CYC);

  // --------------------------------------------------------------------
  // Bias and settle
  // --------------------------------------------------------------------
  wire manual_on = monsel_q == `BMC_SEL_EXT;
  // Any source keeps the bias up; an overlap of auto and manual just
  // merges into one longer on period
  wire bias_on = bias_force | manual_on | auto_on;

  reg  [24:0] settle_cnt_q;
  reg         ext_ot_q;
  wire        settled;

  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      settle_cnt_q <= 25'h0;
    end else if (!bias_on || clr_all) begin
      settle_cnt_q <= 25'h0;
    end else if (!settled) begin
      settle_cnt_q <= settle_cnt_q + 25'h1;
    end
  end

  assign settled = settle_cnt_q == SETTLE_CYC;

  // Sample once settled; with a held bias the flag keeps tracking
  always @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ext_ot_q <= 1'b0;
    end else if (clr_all) begin
      ext_ot_q <= 1'b0;
    end else if (bias_on && settled) begin
      ext_ot_q <= therm_lo_s;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  assign sensor_bias_out_o = bias_on;
  assign monitor_select_o = monsel_q;
  assign thermistor_route_o = manual_on;
  assign ext_over_temp_o = ext_ot_q;
  assign int_over_temp_o = int_ot_s;
  assign user_flags_o = {wren_q[`BMC_B_UF3], wren_q[`BMC_B_UF2],
                         wren_q[`BMC_B_UF1], wren_q[`BMC_B_UF0]};

  // --------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------
  // Sleep bit reads as the inverse of the awake state, so it is seen
  // to clear by itself on wake
  always @* begin
    case (addr)
      `BMC_A_MONSEL: rd_data = {4'h0, monsel_q};
      `BMC_A_CTRL:   rd_data = {~awake_q, 7'h00};
      `BMC_A_FEAT:   rd_data = feat_q;
      `BMC_A_WREN:   rd_data = wren_q;
      default:       rd_data = 8'h00;
    endcase
  end

endmodule
`default_nettype wire

/* verification/bmc_top_props.sv */
// Port-level checker for the battery monitor control block.
// Assumes bmc_top ports and a single core clock domain.
`timescale 1ns/100ps
`default_nettype none
module bmc_top_props #(
  parameter [24:0] SCAN_WIN_CYC = 25'd20,
  parameter [24:0] SCAN_PER_CYC = 25'd200,
  parameter [24:0] SETTLE_CYC   = 25'd5
) (
  input wire logic       core_clk_i,
  input wire logic       nrst_i,
  input wire logic [2:0] cell_por_ok_i,
  input wire logic       vcc_por_ok_i,
  input wire logic       wake_pin_i,
  input wire logic       thermistor_low_i,
  input wire logic       int_over_temp_i,
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       regulator_output_o,
  input wire logic       sensor_bias_out_o,
  input wire logic [3:0] monitor_select_o,
  input wire logic       thermistor_route_o,
  input wire logic       ext_over_temp_o,
  input wire logic       int_over_temp_o,
  input wire logic [3:0] user_flags_o
);
  // ------------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] run_q;
  logic [7:0] run_d;
  // Consecutive bias-on cycles, saturating so it never wraps
  always_comb run_d = (run_q == 8'hff) ? run_q : run_q + 8'h01;
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) run_q <= 8'h00;
    else run_q <= sensor_bias_out_o ? run_d : 8'h00;
  end
  property p_sda_low;
    scl_i && $rose(sda_i) |-> ##[1:4] (!sda_oe_o && !sda_o);
  endproperty
  property p_route;
    thermistor_route_o == (monitor_select_o == 4'h8);
  endproperty
  property p_bias_sel; monitor_select_o == 4'h8 |-> sensor_bias_out_o;
  endproperty
  property p_oe_scl; $changed(sda_oe_o) |-> !scl_i; endproperty
  property p_por_off;
    !(&cell_por_ok_i && vcc_por_ok_i) |-> ##[1:6] !regulator_output_o;
  endproperty
  property p_por_on;
    $rose(&cell_por_ok_i && vcc_por_ok_i) |-> ##[1:8] regulator_output_o;
  endproperty
  property p_ot_settle;
    $rose(ext_over_temp_o) |-> run_q >= SETTLE_CYC;
  endproperty
  property p_int_ot; int_over_temp_i [*4] |-> int_over_temp_o; endproperty
  a_sda_low:   assert property (p_sda_low)
    else $error("data line still pulled after stop");
  a_route:     assert property (p_route)
    else $error("thermistor route disagrees with select");
  a_bias_sel:  assert property (p_bias_sel)
    else $error("bias off while external temp selected");
  a_oe_scl:    assert property (p_oe_scl)
    else $error("data changed while serial clock high");
  a_por_off:   assert property (p_por_off)
    else $error("regulator stayed on after supply loss");
  a_por_on:    assert property (p_por_on)
    else $error("regulator not on after supplies good");
  a_ot_settle: assert property (p_ot_settle)
    else $error("over-temp set before settle delay");
  a_int_ot:    assert property (p_int_ot)
    else $error("internal over-temp not presented");
  c_wake: cover property ($rose(regulator_output_o));
  c_ot:   cover property ($rose(ext_over_temp_o));
  c_ack:  cover property ($rose(sda_oe_o));
endmodule
bind bmc_top bmc_top_props #(.SCAN_WIN_CYC(SCAN_WIN_CYC),
  .SCAN_PER_CYC(SCAN_PER_CYC), .SETTLE_CYC(SETTLE_CYC)) bmc_top_props_i (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .cell_por_ok_i(cell_por_ok_i),
  .vcc_por_ok_i(vcc_por_ok_i), .wake_pin_i(wake_pin_i),
  .thermistor_low_i(thermistor_low_i), .int_over_temp_i(int_over_temp_i),
  .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .regulator_output_o(regulator_output_o),
  .sensor_bias_out_o(sensor_bias_out_o),
  .monitor_select_o(monitor_select_o),
  .thermistor_route_o(thermistor_route_o),
  .ext_over_temp_o(ext_over_temp_o), .int_over_temp_o(int_over_temp_o),
  .user_flags_o(user_flags_o));
`default_nettype wire

/* verification/bmc_host.sv */
// Serial bus master model standing in for the host controller.
// Assumes a pulled-up data wire; one bit takes 8 core clocks (160 ns).
`timescale 1ns/100ps
`default_nettype none
module bmc_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_low_o
);
  // ------------------------------------------------------------------
  // Bus phases
  // ------------------------------------------------------------------
  // Clock stands still high between frames
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Data moves mid-low so the slave never sees it beside a clock edge
  task automatic bitx(input logic b, output logic r);
    sda_low_o <= !b;
    w(2);
    scl_o <= 1'b1;
    w(4);
    r = sda_i;
    scl_o <= 1'b0;
    w(2);
  endtask
  task automatic start;
    sda_low_o <= 1'b0;
    w(2);
    scl_o <= 1'b1;
    w(4);
    sda_low_o <= 1'b1;
    w(4);
    scl_o <= 1'b0;
    w(2);
  endtask
  task automatic stop;
    sda_low_o <= 1'b1;
    w(2);
    scl_o <= 1'b1;
    w(4);
    sda_low_o <= 1'b0;
    w(4);
  endtask
  // Ninth bit: m is what the master puts there, a what it reads back
  task automatic xfer(input logic [7:0] d, input logic m,
                      output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(m, a);
  endtask
endmodule
`default_nettype wire

/* verification/bmc_top_tb.sv */
// Self-checking bench for the battery monitor control block.
// Assumes bmc_host as bus master and shortened scan counts.
`timescale 1ns/100ps
`default_nettype none
`include "bmc_regs.vh"
module bmc_top_tb;
  logic       clk;
  logic       nrst;
  logic [2:0] cell_ok;
  logic       vcc_ok;
  logic       wake;
  logic       th_low;
  logic       iot;
  logic       scl;
  logic       h_low;
  wire        sda_o;
  wire        sda_oe;
  wire        sda_w = ~(h_low | (sda_oe & ~sda_o));
  wire        reg_on;
  wire        bias;
  wire  [3:0] sel;
  wire        route;
  wire        eot;
  wire        iot_o;
  wire  [3:0] flags;
  int         failures = 0;
  int         tests_run = 0;
  int         cyc = 0;
  int         hi;
  int         lo;
  logic [7:0] q;
  logic       k;
  bmc_top #(.SCAN_WIN_CYC(25'd20), .SCAN_PER_CYC(25'd200),
    .SETTLE_CYC(25'd5)) bmc_top_i (
    .core_clk_i(clk), .nrst_i(nrst), .cell_por_ok_i(cell_ok),
    .vcc_por_ok_i(vcc_ok), .wake_pin_i(wake), .thermistor_low_i(th_low),
    .int_over_temp_i(iot), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .regulator_output_o(reg_on),
    .sensor_bias_out_o(bias), .monitor_select_o(sel),
    .thermistor_route_o(route), .ext_over_temp_o(eot),
    .int_over_temp_o(iot_o), .user_flags_o(flags));
  bmc_host host_i (.clk_i(clk), .sda_i(sda_w), .scl_o(scl),
    .sda_low_o(h_low));
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic k0, k1, k2;
    host_i.start();
    host_i.xfer({`BMC_SLV_ADDR, 1'b0}, 1'b1, q, k0);
    host_i.xfer(a, 1'b1, q, k1);
    host_i.xfer(d, 1'b1, q, k2);
    host_i.stop();
    chk({5'h00, k0, k1, k2}, 8'h00);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    logic k0, k1, k2;
    host_i.start();
    host_i.xfer({`BMC_SLV_ADDR, 1'b0}, 1'b1, q, k0);
    host_i.xfer(a, 1'b1, q, k1);
    host_i.start();
    host_i.xfer({`BMC_SLV_ADDR, 1'b1}, 1'b1, q, k2);
    host_i.xfer(8'hff, 1'b1, q, k);
    host_i.stop();
    chk({5'h00, k0, k1, k2}, 8'h00);
    chk(q, exp);
  endtask
  // Bias high run and following low run, each bounded
  task automatic meas;
    hi = 0;
    lo = 0;
    while (bias !== 1'b0 && lo < 400) begin @(posedge clk); lo++; end
    while (bias !== 1'b1 && lo < 800) begin @(posedge clk); lo++; end
    lo = 0;
    while (bias === 1'b1 && hi < 400) begin @(posedge clk); hi++; end
    while (bias === 1'b0 && lo < 400) begin @(posedge clk); lo++; end
  endtask
  task automatic hold(input logic [7:0] exp);
    hi = 0;
    repeat (220) begin @(posedge clk); if (bias === 1'b1) hi++; end
    chk(hi[7:0], exp);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_power;
    chk({3'h0, reg_on, flags}, 8'h10);
    rdc(`BMC_A_WREN, 8'h00);
    cell_ok <= 3'h5;
    repeat (8) @(posedge clk);
    chk({7'h0, reg_on}, 8'h00);
    cell_ok <= 3'h7;
    repeat (8) @(posedge clk);
    chk({6'h0, reg_on, bias}, 8'h03);
  endtask
  task automatic t_scan;
    th_low <= 1'b1;
    meas();
    chk(hi[7:0], 8'h14);
    chk(lo[7:0], 8'hb4);
    chk({7'h0, eot}, 8'h01);
    th_low <= 1'b0;
    repeat (3) @(posedge clk);
    chk({7'h0, eot}, 8'h01);
    repeat (20) @(posedge clk);
    chk({7'h0, eot}, 8'h00);
    th_low <= 1'b1;
    repeat (10) @(posedge clk);
    chk({6'h0, bias, eot}, 8'h00);
    th_low <= 1'b0;
  endtask
  task automatic t_sel;
    wr(`BMC_A_MONSEL, 8'h08);
    hold(8'hdc);
    for (int i = 0; i < 10; i++) begin
      wr(`BMC_A_MONSEL, i[7:0]);
      chk({3'h0, route, sel}, {3'h0, i == 8, i[3:0]});
    end
    wr(`BMC_A_MONSEL, 8'h00);
  endtask
  task automatic t_feat;
    wr(`BMC_A_FEAT, 8'h80);
    rdc(`BMC_A_FEAT, 8'h00);
    wr(`BMC_A_WREN, 8'h80);
    wr(`BMC_A_FEAT, 8'h80);
    rdc(`BMC_A_FEAT, 8'h80);
    hold(8'h00);
    wr(`BMC_A_FEAT, 8'ha0);
    hold(8'hdc);
    wr(`BMC_A_FEAT, 8'h00);
  endtask
  task automatic t_sleep;
    wr(`BMC_A_WREN, 8'hf8);
    chk({4'h0, flags}, 8'h0f);
    wr(`BMC_A_MONSEL, 8'h05);
    for (int p = 0; p < 2; p++) begin
      wr(`BMC_A_FEAT, p[7:0]);
      wake <= p[0];
      wr(`BMC_A_CTRL, 8'h80);
      repeat (4) @(posedge clk);
      chk({7'h0, reg_on}, 8'h00);
      wake <= ~p[0];
      repeat (10) @(posedge clk);
      chk({7'h0, reg_on}, 8'h00);
      wake <= p[0];
      repeat (10) @(posedge clk);
      chk({3'h0, reg_on, flags}, 8'h1f);
      chk({4'h0, sel}, 8'h05);
      rdc(`BMC_A_CTRL, 8'h00);
    end
    wr(`BMC_A_FEAT, 8'h02);
    wr(`BMC_A_CTRL, 8'h80);
    wake <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h0, reg_on}, 8'h00);
    wr(`BMC_A_FEAT, 8'h00);
    wake <= 1'b1;
    repeat (10) @(posedge clk);
    wake <= 1'b0;
    repeat (10) @(posedge clk);
    chk({7'h0, reg_on}, 8'h01);
  endtask
  task automatic t_por;
    wr(`BMC_A_FEAT, 8'h04);
    chk({flags, sel}, 8'h00);
    rdc(`BMC_A_WREN, 8'h00);
    chk({7'h0, reg_on}, 8'h01);
  endtask
  task automatic t_bus;
    host_i.start();
    host_i.xfer({`BMC_SLV_ADDR ^ 7'h01, 1'b0}, 1'b1, q, k);
    host_i.stop();
    chk({7'h0, k}, 8'h01);
    iot <= 1'b1;
    repeat (6) @(posedge clk);
    chk({7'h0, iot_o}, 8'h01);
    iot <= 1'b0;
  endtask
  initial begin
    nrst = 1'b0;
    cell_ok = 3'h7;
    vcc_ok = 1'b1;
    wake = 1'b1;
    th_low = 1'b0;
    iot = 1'b0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    repeat (10) @(posedge clk);
    t_power();
    t_scan();
    t_sel();
    t_feat();
    t_sleep();
    t_por();
    t_bus();
    results();
  end
endmodule
`default_nettype wire
